// ===== src/sti_crc16.sv
`timescale 1ns/1ns
module sti_crc16
#(
    parameter logic [15:0] POLY = sti_frame_pkg::CRC_POLY,
    parameter logic [15:0] SEED = sti_frame_pkg::CRC_SEED
)
(
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_b_i,
    input  wire sti_frame_pkg::crc_bit_t bit_i,
    output logic [15:0]                  crc_o,
    output logic                         done_o
);

    logic [15:0] crc_r;
    logic [15:0] crc_nxt;
    logic [15:0] base;
    logic        done_r;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
        logic fb;
        fb = c[15] ^ d;
        // Shift toward the top stage; XOR only at stages whose coefficient is one
        crc_step = {c[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
    endfunction : crc_step

    always_comb
    begin
        base    = bit_i.first ? SEED : crc_r;
        crc_nxt = crc_step(base, bit_i.bit_val);
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            crc_r <= SEED;
        else if (bit_i.vld)
            crc_r <= crc_nxt;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            done_r <= 1'b0;
        else
            done_r <= bit_i.vld & bit_i.last;
    end

    assign crc_o  = crc_r;
    assign done_o = done_r;

endmodule : sti_crc16

// ===== src/sti_frame_crc_and_timestamp.sv
// Functional notes
// - Checksum polynomial x16+x12+x5+1
// - Preset all sixteen stages to one
// - Bits enter MSB first, one shift each
// - XOR taps at stages with coefficient one
// - Transmit the complemented register as check word
// - Receiver residue 1D0F means no error
// - Timestamp is 24-bit count of reference periods
// - Levels 7,3,8,3,3 bits with range limits
// - Real timestamps span zero to F9FFFF
// - All ones is the null timestamp
// - FA0000 to FFFFFE reserved, never generated
// - Unused finer levels forced to zero
// - Five levels, 8 ms down to 61 ns
// - Frame field: FF then three timestamp bytes
`timescale 1ns/1ns
module sti_frame_crc_and_timestamp
#(
    parameter int TS_W = sti_frame_pkg::TS_W
)
(
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_b_i,
    // Transmit checksum stream
    input  wire sti_frame_pkg::crc_bit_t  tx_bit_i,
    output logic [15:0]                   tx_check_o,
    output logic                          tx_check_vld_o,
    // Receive checksum stream, check word included
    input  wire sti_frame_pkg::crc_bit_t  rx_bit_i,
    output logic                          rx_done_o,
    output logic                          rx_crc_err_o,
    // Timestamp generation
    input  wire logic                     gen_req_i,
    input  wire logic                     gen_null_i,
    input  wire logic [2:0]               gen_level_i,
    input  wire logic [TS_W-1:0]          gen_ts_i,
    output logic [31:0]                   gen_field_o,
    output logic                          gen_vld_o,
    output logic                          gen_refused_o,
    // Timestamp checking
    input  wire logic                     chk_req_i,
    input  wire logic [31:0]              chk_field_i,
    output sti_frame_pkg::ts_class_t      chk_class_o,
    output logic                          chk_fill_err_o,
    output logic                          chk_vld_o
);

    logic [15:0]              tx_crc;
    logic                     tx_done;
    logic [15:0]              rx_crc;
    logic                     rx_done;
    logic [15:0]              tx_check_r;
    logic                     tx_check_vld_r;
    logic                     rx_crc_err_r;
    logic                     rx_done_r;
    logic [TS_W-1:0]          gen_mask;
    logic [TS_W-1:0]          gen_ts_nxt;
    logic                     gen_bad;
    logic [31:0]              gen_field_r;
    logic                     gen_vld_r;
    logic                     gen_refused_r;
    logic [TS_W-1:0]          chk_ts;
    sti_frame_pkg::ts_class_t chk_class_nxt;
    sti_frame_pkg::ts_class_t chk_class_r;
    logic                     chk_fill_err_r;
    logic                     chk_vld_r;

    sti_crc16 u_tx_crc
    (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .bit_i     (tx_bit_i),
        .crc_o     (tx_crc),
        .done_o    (tx_done)
    );

    sti_crc16 u_rx_crc
    (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .bit_i     (rx_bit_i),
        .crc_o     (rx_crc),
        .done_o    (rx_done)
    );

    // Level one range check, used by the checker only
    function automatic logic fields_ok(input logic [TS_W-1:0] t);
        logic [6:0] l1;
        l1 = t[TS_W-1:sti_frame_pkg::L1_LSB];
        fields_ok = (l1 <= sti_frame_pkg::L1_MAX) || (l1 == sti_frame_pkg::L1_ALT);
    endfunction : fields_ok

    // Mask keeping levels 1..lvl; finer fields cleared
    function automatic logic [TS_W-1:0] level_mask(input logic [2:0] lvl);
        unique case (lvl)
            3'h1:    level_mask = ~((24'h000001 << sti_frame_pkg::L1_LSB) - 24'h000001);
            3'h2:    level_mask = ~((24'h000001 << sti_frame_pkg::L2_LSB) - 24'h000001);
            3'h3:    level_mask = ~((24'h000001 << sti_frame_pkg::L3_LSB) - 24'h000001);
            3'h4:    level_mask = ~((24'h000001 << sti_frame_pkg::L4_LSB) - 24'h000001);
            default: level_mask = 24'hFFFFFF;
        endcase
    endfunction : level_mask

    // Transmit check word
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_check_r     <= 16'h0000;
            tx_check_vld_r <= 1'b0;
        end
        else
        begin
            tx_check_vld_r <= tx_done;
            if (tx_done)
                tx_check_r <= ~tx_crc;
        end
    end

    // Receive residue check
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rx_crc_err_r <= 1'b0;
            rx_done_r    <= 1'b0;
        end
        else
        begin
            rx_done_r <= rx_done;
            if (rx_done)
                rx_crc_err_r <= (rx_crc != sti_frame_pkg::CRC_RESIDUE);
        end
    end

    // Generation: count of reference periods, coarse levels kept
    always_comb
    begin
        gen_mask   = level_mask(gen_level_i);
        gen_ts_nxt = gen_ts_i & gen_mask;
        gen_bad    = !gen_null_i && ((gen_ts_nxt > sti_frame_pkg::TS_MAX_REAL)
                     || (gen_level_i < sti_frame_pkg::LVL_MIN)
                     || (gen_level_i > sti_frame_pkg::LVL_MAX));
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            gen_field_r   <= 32'h00000000;
            gen_vld_r     <= 1'b0;
            gen_refused_r <= 1'b0;
        end
        else
        begin
            gen_vld_r     <= gen_req_i && !gen_bad;
            gen_refused_r <= gen_req_i && gen_bad;
            if (gen_req_i && !gen_bad)
            begin
                // Byte order FF, bits 0-7 (MSb end), 8-15, 16-23
                if (gen_null_i)
                    gen_field_r <= {sti_frame_pkg::TS_FILL, sti_frame_pkg::TS_NULL};
                else
                    gen_field_r <= {sti_frame_pkg::TS_FILL, gen_ts_nxt};
            end
        end
    end

    // Checking and classification
    always_comb
    begin
        chk_ts                  = chk_field_i[TS_W-1:0];
        chk_class_nxt.null_ts   = (chk_ts == sti_frame_pkg::TS_NULL);
        chk_class_nxt.reserved  = (chk_ts > sti_frame_pkg::TS_MAX_REAL)
                                  && !chk_class_nxt.null_ts;
        chk_class_nxt.range_err = !chk_class_nxt.null_ts && !fields_ok(chk_ts);
        chk_class_nxt.valid     = (chk_ts <= sti_frame_pkg::TS_MAX_REAL)
                                  && !chk_class_nxt.range_err;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            chk_class_r    <= '0;
            chk_fill_err_r <= 1'b0;
            chk_vld_r      <= 1'b0;
        end
        else
        begin
            chk_vld_r <= chk_req_i;
            if (chk_req_i)
            begin
                chk_class_r    <= chk_class_nxt;
                chk_fill_err_r <= (chk_field_i[31:TS_W] != sti_frame_pkg::TS_FILL);
            end
        end
    end

    assign tx_check_o     = tx_check_r;
    assign tx_check_vld_o = tx_check_vld_r;
    assign rx_done_o      = rx_done_r;
    assign rx_crc_err_o   = rx_crc_err_r;
    assign gen_field_o    = gen_field_r;
    assign gen_vld_o      = gen_vld_r;
    assign gen_refused_o  = gen_refused_r;
    assign chk_class_o    = chk_class_r;
    assign chk_fill_err_o = chk_fill_err_r;
    assign chk_vld_o      = chk_vld_r;

    // A lone zero bit starting from the preset gives a known check word
    a_tx_check_word: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tx_bit_i.vld && tx_bit_i.first && tx_bit_i.last && !tx_bit_i.bit_val
        |-> ##2 tx_check_vld_o && (tx_check_o == 16'h1020))
        else $error("check word after single zero bit wrong");

    a_crc_preset: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tx_bit_i.vld && tx_bit_i.first && tx_bit_i.bit_val
        |=> tx_crc == 16'hFFFE)
        else $error("preset or shift wrong on first bit");

    a_crc_taps: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tx_bit_i.vld && !tx_bit_i.first
        |=> tx_crc == ({$past(tx_crc[14:0]), 1'b0}
                ^ (($past(tx_crc[15]) ^ $past(tx_bit_i.bit_val)) ? 16'h1021 : 16'h0000)))
        else $error("checksum shift wrong");

    a_crc_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !tx_bit_i.vld |=> $stable(tx_crc))
        else $error("checksum moved without a bit");

    a_rx_residue: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        rx_done |=> rx_done_o && (rx_crc_err_o == ($past(rx_crc) != 16'h1D0F)))
        else $error("residue compare wrong");

    a_gen_range: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        gen_vld_o |-> (gen_field_o[23:0] <= 24'hF9FFFF) || (gen_field_o[23:0] == 24'hFFFFFF))
        else $error("reserved timestamp generated");

    a_gen_levels: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        gen_req_i && !gen_null_i && (gen_level_i == 3'h2) && !gen_bad
        |=> gen_vld_o && (gen_field_o[13:0] == 14'h0000))
        else $error("unused level not cleared");

    a_gen_null: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        gen_req_i && gen_null_i |=> gen_vld_o && (gen_field_o == 32'hFFFFFFFF))
        else $error("null timestamp not produced");

    a_chk_classes: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        chk_vld_o |-> $onehot0({chk_class_o.valid, chk_class_o.null_ts, chk_class_o.reserved})
        && !(chk_class_o.valid && chk_class_o.range_err))
        else $error("timestamp classes overlap");

    a_chk_level1: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        chk_req_i && (chk_field_i[23:17] == 7'h7D) |=> chk_class_o.range_err)
        else $error("level one range not flagged");

    c_tx_frame: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) tx_check_vld_o);
    c_rx_good:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        rx_done_o && !rx_crc_err_o);
    c_ts_null:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        chk_vld_o && chk_class_o.null_ts);
    c_ts_resv:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        chk_vld_o && chk_class_o.reserved);

endmodule : sti_frame_crc_and_timestamp

// ===== src/sti_frame_pkg.sv
package sti_frame_pkg;

    // Checksum engine
    localparam int          CRC_W       = 16;
    localparam logic [15:0] CRC_POLY    = 16'h1021;
    localparam logic [15:0] CRC_SEED    = 16'hFFFF;
    localparam logic [15:0] CRC_RESIDUE = 16'h1D0F;

    // Timestamp coding
    localparam int          TS_W        = 24;
    localparam real         TS_REF_MHZ  = 16.384;
    localparam logic [23:0] TS_MAX_REAL = 24'hF9FFFF;
    localparam logic [23:0] TS_NULL     = 24'hFFFFFF;
    localparam logic [7:0]  TS_FILL     = 8'hFF;

    // Level fields, from the most significant end
    localparam int          L1_LSB      = 17;
    localparam int          L2_LSB      = 14;
    localparam int          L3_LSB      = 6;
    localparam int          L4_LSB      = 3;
    localparam int          L5_LSB      = 0;
    localparam logic [6:0]  L1_MAX      = 7'h7C;
    localparam logic [6:0]  L1_ALT      = 7'h7F;

    // Approximate resolutions, ns
    localparam real         RES_L1_NS   = 8000000.0;
    localparam real         RES_L2_NS   = 1000000.0;
    localparam real         RES_L3_NS   = 3910.0;
    localparam real         RES_L4_NS   = 488.0;
    localparam real         RES_L5_NS   = 61.0;

    localparam logic [2:0]  LVL_MIN     = 3'h1;
    localparam logic [2:0]  LVL_MAX     = 3'h5;

    typedef struct packed {
        logic valid;
        logic null_ts;
        logic reserved;
        logic range_err;
    } ts_class_t;

    typedef struct packed {
        logic        vld;
        logic        bit_val;
        logic        first;
        logic        last;
    } crc_bit_t;

endpackage : sti_frame_pkg

// ===== tb/sti_frame_crc_and_timestamp_tb.sv
`timescale 1ns/1ns
module sti_frame_crc_and_timestamp_tb;
    logic                     ref_clk_i;
    logic                     rst_b_i;
    sti_frame_pkg::crc_bit_t  tx_bit, rx_bit;
    logic [15:0]              tx_check;
    logic                     tx_vld, rx_done, rx_err, tx_busy, rx_busy;
    logic                     tx_go, rx_go, gen_req, gen_null, gen_vld, gen_ref;
    logic [47:0]              tx_word, rx_word;
    logic [5:0]               tx_len, rx_len;
    logic [2:0]               gen_level;
    logic [23:0]              gen_ts;
    logic [31:0]              gen_field, chk_field;
    logic                     chk_req, chk_fill, chk_vld;
    sti_frame_pkg::ts_class_t chk_class;
    int                       n_fail, total_checks;
    int                       lsb [1:5] = '{17, 14, 6, 3, 0};

    sti_frame_crc_and_timestamp DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .tx_bit_i(tx_bit), .tx_check_o(tx_check), .tx_check_vld_o(tx_vld),
        .rx_bit_i(rx_bit), .rx_done_o(rx_done), .rx_crc_err_o(rx_err),
        .gen_req_i(gen_req), .gen_null_i(gen_null), .gen_level_i(gen_level),
        .gen_ts_i(gen_ts), .gen_field_o(gen_field), .gen_vld_o(gen_vld),
        .gen_refused_o(gen_ref), .chk_req_i(chk_req), .chk_field_i(chk_field),
        .chk_class_o(chk_class), .chk_fill_err_o(chk_fill), .chk_vld_o(chk_vld));
    sti_frame_partner tx_src (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .go_i(tx_go),
        .word_i(tx_word), .len_i(tx_len), .bit_o(tx_bit), .busy_o(tx_busy));
    sti_frame_partner rx_src (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .go_i(rx_go),
        .word_i(rx_word), .len_i(rx_len), .bit_o(rx_bit), .busy_o(rx_busy));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Own bit-serial model, MSB first from an all-ones preset
    function automatic logic [15:0] crc_of(input logic [47:0] w, input int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = n - 1; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction : crc_of

    task automatic send(input logic rx, input logic [47:0] w, input logic [5:0] n);
        int k;
        k = 0;
        do
        begin
            @(posedge ref_clk_i);
            k++;
        end while ((rx ? rx_busy : tx_busy) !== 1'b0 && k < 100);
        if (k >= 100)
        begin
            n_fail++;
            print_verdict();
        end
        if (rx)
            {rx_go, rx_word, rx_len} <= {1'b1, w, n};
        else
            {tx_go, tx_word, tx_len} <= {1'b1, w, n};
        @(posedge ref_clk_i);
        rx_go <= 1'b0;
        tx_go <= 1'b0;
    endtask : send

    task automatic wait_done(input logic rx);
        int k;
        k = 0;
        do
        begin
            @(posedge ref_clk_i);
            #1;
            k++;
        end while ((rx ? rx_done : tx_vld) !== 1'b1 && k < 100);
        if (k >= 100)
        begin
            n_fail++;
            print_verdict();
        end
    endtask : wait_done

    task automatic tx_crc;
        send(1'b0, 48'h0, 6'h01);
        wait_done(1'b0);
        check(tx_check, 16'(~crc_of(48'h0, 1)));
        send(1'b0, 48'h1234, 6'h10);
        send(1'b0, 48'hBEEF, 6'h10);
        wait_done(1'b0);
        check(tx_check, 16'(~crc_of(48'h1234, 16)));
        wait_done(1'b0);
        check(tx_check, 16'(~crc_of(48'hBEEF, 16)));
    endtask : tx_crc

    task automatic rx_crc;
        logic [15:0] c;
        c = ~crc_of(48'hA55A, 16);
        send(1'b1, {16'h0000, 16'hA55A, c}, 6'h20);
        wait_done(1'b1);
        check(rx_err, 1'b0);
        send(1'b1, {16'h0000, 16'hA55A, c ^ 16'h0001}, 6'h20);
        wait_done(1'b1);
        check(rx_err, 1'b1);
    endtask : rx_crc

    task automatic gen_one(input logic nl, input logic [2:0] lv, input logic [23:0] ts,
                           input logic ok, input logic [31:0] fld);
        @(posedge ref_clk_i);
        {gen_req, gen_null, gen_level, gen_ts} <= {1'b1, nl, lv, ts};
        @(posedge ref_clk_i);
        gen_req <= 1'b0;
        #1;
        check(gen_vld, ok);
        check(gen_ref, !ok);
        check(gen_field, fld);
    endtask : gen_one

    task automatic gen_fields;
        for (int l = 1; l <= 5; l++)
            gen_one(1'b0, 3'(l), 24'hF9ABCD, 1'b1,
                    {8'hFF, 24'hF9ABCD & (24'hFFFFFF << lsb[l])});
        gen_one(1'b1, 3'h2, 24'h123456, 1'b1, 32'hFFFFFFFF);
        gen_one(1'b0, 3'h5, 24'hF9FFFF, 1'b1, 32'hFFF9FFFF);
        gen_one(1'b0, 3'h5, 24'hFA0000, 1'b0, 32'hFFF9FFFF);
        gen_one(1'b0, 3'h3, 24'hFFFFFE, 1'b0, 32'hFFF9FFFF);
        gen_one(1'b0, 3'h0, 24'h000001, 1'b0, 32'hFFF9FFFF);
        gen_one(1'b0, 3'h6, 24'h000001, 1'b0, 32'hFFF9FFFF);
        gen_one(1'b0, 3'h7, 24'h000001, 1'b0, 32'hFFF9FFFF);
    endtask : gen_fields

    task automatic chk_one(input logic [31:0] f, input logic [3:0] cls, input logic fe);
        @(posedge ref_clk_i);
        {chk_req, chk_field} <= {1'b1, f};
        @(posedge ref_clk_i);
        chk_req <= 1'b0;
        #1;
        check(chk_vld, 1'b1);
        check(chk_class, cls);
        check(chk_fill, fe);
    endtask : chk_one

    task automatic chk_fields;
        chk_one(32'hFF000000, 4'h8, 1'b0);
        chk_one(32'hFFF9FFFF, 4'h8, 1'b0);
        chk_one(32'hFFFFFFFF, 4'h4, 1'b0);
        chk_one(32'hFFFA0000, 4'h3, 1'b0);
        chk_one(32'hFFFFFFFE, 4'h2, 1'b0);
        chk_one(32'h00F9FFFF, 4'h8, 1'b1);
    endtask : chk_fields

    initial
    begin
        {rst_b_i, tx_go, rx_go, gen_req, gen_null, chk_req} = 6'h00;
        {tx_word, rx_word, tx_len, rx_len} = '0;
        {gen_level, gen_ts, chk_field} = '0;
        n_fail = 0;
        total_checks = 0;
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        #1;
        check(gen_field, 32'h0);
        check(chk_class, 4'h0);
        check({tx_check, tx_vld, rx_done, rx_err, gen_vld, gen_ref, chk_fill, chk_vld}, 32'h0);
        tx_crc();
        rx_crc();
        gen_fields();
        chk_fields();
        print_verdict();
    end
endmodule : sti_frame_crc_and_timestamp_tb

// ===== tb/sti_frame_partner.sv
`timescale 1ns/1ns
module sti_frame_partner
(
    input  wire logic               ref_clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               go_i,
    input  wire logic [47:0]        word_i,
    input  wire logic [5:0]         len_i,
    output sti_frame_pkg::crc_bit_t bit_o,
    output logic                    busy_o
);
    logic [47:0] sh_r;
    logic [5:0]  cnt_r;
    logic [5:0]  len_r;
    logic        idle_r;
    // Idle data toggles so a stale bit never passes for a real one
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sh_r   <= '0;
            cnt_r  <= 6'h00;
            len_r  <= 6'h00;
            idle_r <= 1'b0;
        end
        else
        begin
            idle_r <= ~idle_r;
            if (go_i && cnt_r <= 6'h01)
            begin
                sh_r  <= word_i << (7'h30 - len_i);
                cnt_r <= len_i;
                len_r <= len_i;
            end
            else if (cnt_r != 6'h00)
            begin
                sh_r  <= sh_r << 1;
                cnt_r <= cnt_r - 6'h01;
            end
        end
    end
    // Busy drops two bits early so the next block follows with no gap
    assign busy_o        = cnt_r > 6'h02;
    assign bit_o.vld     = cnt_r != 6'h00;
    assign bit_o.bit_val = bit_o.vld ? sh_r[47] : idle_r;
    assign bit_o.first   = bit_o.vld && cnt_r == len_r;
    assign bit_o.last    = cnt_r == 6'h01;
endmodule : sti_frame_partner
